// ---- core/eau_pkg.sv ----
// constants, types and carriers of the effective address unit
package eau_pkg;

  localparam int unsigned REG_COUNT = 8;
  localparam logic [2:0] SP_REG = 3'h7;
  localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] STEP_WORD = 32'h0000_0002;
  localparam logic [31:0] STEP_LONG = 32'h0000_0004;
  localparam logic [31:0] STACK_SLOT = 32'h0000_0004;
  localparam logic [31:0] EXT_VEC_BASE = 32'h0000_0000;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  typedef enum logic [3:0] {
    MODE_REG_DIR = 4'h0,
    MODE_REG_IND = 4'h1,
    MODE_REG_DISP = 4'h2,
    MODE_REG_IDX = 4'h3,
    MODE_POST_INC = 4'h4,
    MODE_PRE_DEC = 4'h5,
    MODE_PRE_INC = 4'h6,
    MODE_POST_DEC = 4'h7,
    MODE_ABS = 4'h8,
    MODE_IMM = 4'h9,
    MODE_PC_REL = 4'ha,
    MODE_PC_IDX = 4'hb,
    MODE_MEM_IND = 4'hc,
    MODE_EXT_MEM_IND = 4'hd
  } eau_mode_type;

  typedef enum logic [2:0] {
    CLS_GEN = 3'h0,
    CLS_JUMP = 3'h1,
    CLS_JSR = 3'h2,
    CLS_BIT = 3'h3,
    CLS_BIT_SCIT = 3'h4
  } eau_class_type;

  typedef enum logic [1:0] {
    OP_EA = 2'h0,
    OP_RET = 2'h1,
    OP_EXC_IN = 2'h2,
    OP_EXC_OUT = 2'h3
  } eau_op_type;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } eau_size_type;

  typedef enum logic [1:0] {
    DISP_2 = 2'h0,
    DISP_8 = 2'h1,
    DISP_16 = 2'h2,
    DISP_32 = 2'h3
  } eau_disp_type;

  typedef struct packed {
    eau_op_type op;
    eau_class_type cls;
    eau_mode_type mode;
    eau_size_type size;
    logic reg_hi;
    logic [2:0] base_reg;
    logic [2:0] index_reg;
    eau_size_type index_size;
    eau_disp_type disp_sel;
    logic [31:0] disp;
    logic [31:0] abs_addr;
    logic [31:0] imm;
    logic bit_from_reg;
    logic [31:0] pc;
    logic [7:0] condition_code_reg;
    logic [7:0] extended_control_reg;
  } eau_req_type;

  typedef struct packed {
    logic illegal;
    logic [31:0] ea;
    logic [31:0] operand;
    logic [31:0] target;
    logic [2:0] bitnum;
    logic restored;
    logic [7:0] condition_code_reg;
    logic [7:0] extended_control_reg;
  } eau_res_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } eau_mem_type;

endpackage

// ---- core/eau_regfile.sv ----
// general register file with registered read ports
`timescale 1ns/1ps
`default_nettype none
module eau_regfile #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = eau_pkg::REG_COUNT
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // read ports
  input wire logic [$clog2(DEPTH)-1:0] raddr_a,
  input wire logic [$clog2(DEPTH)-1:0] raddr_b,
  output logic [WIDTH-1:0] rdata_a,
  output logic [WIDTH-1:0] rdata_b,
  // write port
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [WIDTH-1:0] next_rdata_a;
  logic [WIDTH-1:0] next_rdata_b;

  // write-first so a read right behind an update sees it
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      next_mem[i] = (we && waddr == i[$clog2(DEPTH)-1:0]) ? wdata : mem[i];
    end
    next_rdata_a = next_mem[raddr_a];
    next_rdata_b = next_mem[raddr_b];
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= WIDTH'(eau_pkg::REG_RESET);
      end
      rdata_a <= WIDTH'(eau_pkg::REG_RESET);
      rdata_b <= WIDTH'(eau_pkg::REG_RESET);
    end else begin
      mem <= next_mem;
      rdata_a <= next_rdata_a;
      rdata_b <= next_rdata_b;
    end
  end
endmodule
`default_nettype wire

// ---- core/eau_unit.sv ----
// effective address unit: mode decode, address forming and stacking
`timescale 1ns/1ps
`default_nettype none
module eau_unit (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // request from the decoder
  input wire logic req_valid,
  output logic req_ready,
  input wire eau_pkg::eau_req_type req,
  // result
  output logic res_valid,
  output eau_pkg::eau_res_type res,
  // memory access port
  output eau_pkg::eau_mem_type mem,
  input wire logic mem_ready,
  input wire logic [31:0] mem_rdata,
  // register write from execution
  input wire logic ext_we,
  input wire logic [2:0] ext_waddr,
  input wire logic [31:0] ext_wdata
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_READ = 4'h1,
    ST_CALC = 4'h2,
    ST_IND = 4'h3,
    ST_PUSH_PC = 4'h4,
    ST_PUSH_CX = 4'h5,
    ST_POP_CX = 4'h6,
    ST_POP_PC = 4'h7,
    ST_DONE = 4'h8
  } eau_state_type;

  eau_state_type state, next_state;
  eau_pkg::eau_req_type cur, next_cur;
  eau_pkg::eau_res_type next_res;
  eau_pkg::eau_mem_type next_mem;
  logic [31:0] sp, next_sp;
  logic next_res_valid;
  logic [31:0] rd_a, rd_b;
  logic [2:0] raddr_a, raddr_b;
  logic int_we;
  logic [2:0] int_waddr;
  logic [31:0] int_wdata;
  logic [31:0] disp_x, idx_x, step, reg_val, ea;
  logic legal, sp_on_b;

  // internal updates win over an execution write in the same cycle
  eau_regfile #(.WIDTH(32), .DEPTH(eau_pkg::REG_COUNT)) u_regs (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .raddr_a(raddr_a),
    .raddr_b(raddr_b),
    .rdata_a(rd_a),
    .rdata_b(rd_b),
    .we(int_we | ext_we),
    .waddr(int_we ? int_waddr : ext_waddr),
    .wdata(int_we ? int_wdata : ext_wdata)
  );

  function automatic logic mode_ok(eau_pkg::eau_class_type c, eau_pkg::eau_mode_type m);
    logic ok;
    ok = 1'b0;
    case (c)
      eau_pkg::CLS_JUMP, eau_pkg::CLS_JSR: begin
        ok = m inside {eau_pkg::MODE_REG_IND, eau_pkg::MODE_ABS, eau_pkg::MODE_PC_REL,
                       eau_pkg::MODE_PC_IDX, eau_pkg::MODE_MEM_IND,
                       eau_pkg::MODE_EXT_MEM_IND};
      end
      eau_pkg::CLS_BIT, eau_pkg::CLS_BIT_SCIT: begin
        ok = m inside {eau_pkg::MODE_REG_DIR, eau_pkg::MODE_REG_IND,
                       eau_pkg::MODE_ABS};
      end
      eau_pkg::CLS_GEN: begin
        ok = m <= eau_pkg::MODE_IMM;
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction

  function automatic logic [31:0] size_ext(logic [31:0] v, eau_pkg::eau_size_type s);
    logic [31:0] r;
    case (s)
      eau_pkg::SZ_BYTE: r = {24'h00_0000, v[7:0]};
      eau_pkg::SZ_WORD: r = {16'h0000, v[15:0]};
      default: r = v;
    endcase
    return r;
  endfunction

  assign req_ready = (state == ST_IDLE);

  // register reads are issued one cycle ahead of the calculation
  always_comb begin
    sp_on_b = cur.op == eau_pkg::OP_EA && cur.cls == eau_pkg::CLS_JSR &&
              cur.mode != eau_pkg::MODE_PC_IDX;
    raddr_a = (cur.op == eau_pkg::OP_EA && (sp_on_b || cur.cls != eau_pkg::CLS_JSR)) ?
              cur.base_reg : eau_pkg::SP_REG;
    raddr_b = sp_on_b ? eau_pkg::SP_REG : cur.index_reg;
  end

  // operand forming
  always_comb begin
    case (cur.disp_sel)
      eau_pkg::DISP_2: disp_x = {30'h0000_0000, cur.disp[1:0]};
      eau_pkg::DISP_8: disp_x = {{24{cur.disp[7]}}, cur.disp[7:0]};
      eau_pkg::DISP_16: disp_x = {{16{cur.disp[15]}}, cur.disp[15:0]};
      default: disp_x = cur.disp;
    endcase
    idx_x = size_ext(rd_b, cur.index_size);
    case (cur.size)
      eau_pkg::SZ_BYTE: step = eau_pkg::STEP_BYTE;
      eau_pkg::SZ_WORD: step = eau_pkg::STEP_WORD;
      default: step = eau_pkg::STEP_LONG;
    endcase
    case (cur.size)
      eau_pkg::SZ_BYTE: reg_val = {24'h00_0000, cur.reg_hi ? rd_a[15:8] : rd_a[7:0]};
      eau_pkg::SZ_WORD: reg_val = {16'h0000, cur.reg_hi ? rd_a[31:16] : rd_a[15:0]};
      default: reg_val = rd_a;
    endcase
    legal = mode_ok(cur.cls, cur.mode) &&
            (!cur.bit_from_reg || cur.cls == eau_pkg::CLS_BIT_SCIT);
    case (cur.mode)
      eau_pkg::MODE_REG_DISP: ea = rd_a + disp_x;
      eau_pkg::MODE_REG_IDX: ea = idx_x + disp_x;
      eau_pkg::MODE_PRE_DEC: ea = rd_a - step;
      eau_pkg::MODE_PRE_INC: ea = rd_a + step;
      eau_pkg::MODE_ABS: ea = cur.abs_addr;
      eau_pkg::MODE_PC_REL: ea = cur.pc + disp_x;
      eau_pkg::MODE_PC_IDX: ea = cur.pc + idx_x;
      eau_pkg::MODE_MEM_IND: ea = {24'h00_0000, cur.abs_addr[7:0]};
      eau_pkg::MODE_EXT_MEM_IND: ea = eau_pkg::EXT_VEC_BASE + {23'h00_0000, cur.abs_addr[6:0], 2'h0};
      default: ea = rd_a;
    endcase
  end

  always_comb begin
    next_state = state;
    next_cur = cur;
    next_res = res;
    next_res_valid = 1'b0;
    next_mem = mem;
    next_sp = sp;
    int_we = 1'b0;
    int_waddr = eau_pkg::SP_REG;
    int_wdata = sp;
    case (state)
      ST_IDLE: begin
        if (req_valid) begin
          next_cur = req;
          next_res = '0;
          next_state = ST_READ;
        end
      end
      ST_READ: begin
        next_state = ST_CALC;
      end
      ST_CALC: begin
        next_sp = sp_on_b ? rd_b : rd_a;
        case (cur.op)
          eau_pkg::OP_EA: begin
            next_res.illegal = !legal;
            next_res.ea = ea;
            next_res.operand = (cur.mode == eau_pkg::MODE_IMM) ? cur.imm : reg_val;
            next_res.target = ea;
            next_res.bitnum = cur.bit_from_reg ? rd_b[2:0] : cur.imm[2:0];
            if (legal && cur.mode inside {eau_pkg::MODE_POST_INC, eau_pkg::MODE_PRE_INC}) begin
              int_we = 1'b1;
              int_waddr = cur.base_reg;
              int_wdata = rd_a + step;
            end
            if (legal && cur.mode inside {eau_pkg::MODE_POST_DEC, eau_pkg::MODE_PRE_DEC}) begin
              int_we = 1'b1;
              int_waddr = cur.base_reg;
              int_wdata = rd_a - step;
            end
            if (!legal) begin
              next_state = ST_DONE;
            end else if (cur.mode inside {eau_pkg::MODE_MEM_IND, eau_pkg::MODE_EXT_MEM_IND}) begin
              next_mem = '{rd: 1'b1, wr: 1'b0, addr: ea, wdata: 32'h0000_0000};
              next_state = ST_IND;
            end else if (cur.cls == eau_pkg::CLS_JSR) begin
              next_mem = '{rd: 1'b0, wr: 1'b1, addr: (sp_on_b ? rd_b : rd_a) -
                           eau_pkg::STACK_SLOT, wdata: cur.pc};
              next_state = ST_PUSH_PC;
            end else begin
              next_state = ST_DONE;
            end
          end
          eau_pkg::OP_EXC_IN: begin
            next_res.target = cur.abs_addr;
            next_mem = '{rd: 1'b0, wr: 1'b1, addr: rd_a - eau_pkg::STACK_SLOT,
                         wdata: cur.pc};
            next_state = ST_PUSH_PC;
          end
          eau_pkg::OP_EXC_OUT: begin
            next_mem = '{rd: 1'b1, wr: 1'b0, addr: rd_a, wdata: 32'h0000_0000};
            next_state = ST_POP_CX;
          end
          default: begin
            next_mem = '{rd: 1'b1, wr: 1'b0, addr: rd_a, wdata: 32'h0000_0000};
            next_state = ST_POP_PC;
          end
        endcase
      end
      ST_IND: begin
        if (mem_ready) begin
          next_res.target = mem_rdata;
          if (cur.cls == eau_pkg::CLS_JSR) begin
            next_mem = '{rd: 1'b0, wr: 1'b1, addr: sp - eau_pkg::STACK_SLOT,
                         wdata: cur.pc};
            next_state = ST_PUSH_PC;
          end else begin
            next_mem = '0;
            next_state = ST_DONE;
          end
        end
      end
      ST_PUSH_PC: begin
        if (mem_ready) begin
          next_sp = sp - eau_pkg::STACK_SLOT;
          int_we = 1'b1;
          int_wdata = next_sp;
          if (cur.op == eau_pkg::OP_EXC_IN) begin
            next_mem = '{rd: 1'b0, wr: 1'b1, addr: next_sp - eau_pkg::STACK_SLOT,
                         wdata: {cur.extended_control_reg, cur.condition_code_reg,
                                 16'h0000}};
            next_state = ST_PUSH_CX;
          end else begin
            next_mem = '0;
            next_state = ST_DONE;
          end
        end
      end
      ST_PUSH_CX: begin
        if (mem_ready) begin
          next_sp = sp - eau_pkg::STACK_SLOT;
          int_we = 1'b1;
          int_wdata = next_sp;
          next_mem = '0;
          next_state = ST_DONE;
        end
      end
      ST_POP_CX: begin
        if (mem_ready) begin
          next_sp = sp + eau_pkg::STACK_SLOT;
          int_we = 1'b1;
          int_wdata = next_sp;
          next_res.extended_control_reg = mem_rdata[31:24];
          next_res.condition_code_reg = mem_rdata[23:16];
          next_res.restored = 1'b1;
          next_mem = '{rd: 1'b1, wr: 1'b0, addr: next_sp, wdata: 32'h0000_0000};
          next_state = ST_POP_PC;
        end
      end
      ST_POP_PC: begin
        if (mem_ready) begin
          next_sp = sp + eau_pkg::STACK_SLOT;
          int_we = 1'b1;
          int_wdata = next_sp;
          next_res.target = mem_rdata;
          next_mem = '0;
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_res_valid = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      cur <= '0;
      res <= '0;
      res_valid <= 1'b0;
      mem <= '0;
      sp <= eau_pkg::REG_RESET;
    end else begin
      state <= next_state;
      cur <= next_cur;
      res <= next_res;
      res_valid <= next_res_valid;
      mem <= next_mem;
      sp <= next_sp;
    end
  end
endmodule
`default_nettype wire

// ---- bench/eau_unit_chk.sv ----
// checker of the effective address unit ports
`timescale 1ns/1ps
`default_nettype none
module eau_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // request and result
  input wire logic req_valid,
  input wire logic req_ready,
  input wire eau_pkg::eau_req_type req,
  input wire logic res_valid,
  input wire eau_pkg::eau_res_type res,
  // memory port
  input wire eau_pkg::eau_mem_type mem,
  input wire logic mem_ready,
  input wire logic [31:0] mem_rdata
);
  wire logic tk;
  wire logic jm;
  logic ind_pend, push_pend, exc_pend;
  logic [1:0] wr_cnt;
  logic [31:0] rd_last, pc_hold;
  logic [7:0] ccr_hold, exr_hold;
  assign tk = req_valid && req_ready;
  assign jm = req.op == eau_pkg::OP_EA && req.cls == eau_pkg::CLS_JUMP;

  // counts completed writes so each stacked longword is judged by position
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {ind_pend, push_pend, exc_pend, wr_cnt} <= '0;
      {rd_last, pc_hold, ccr_hold, exr_hold} <= '0;
    end else begin
      if (tk) begin
        ind_pend <= jm && req.mode inside {eau_pkg::MODE_MEM_IND, eau_pkg::MODE_EXT_MEM_IND};
        push_pend <= req.op == eau_pkg::OP_EXC_IN || (req.op == eau_pkg::OP_EA
          && req.cls == eau_pkg::CLS_JSR);
        exc_pend <= req.op == eau_pkg::OP_EXC_IN;
        pc_hold <= req.pc;
        ccr_hold <= req.condition_code_reg;
        exr_hold <= req.extended_control_reg;
        wr_cnt <= 2'h0;
      end else if (res_valid) begin
        {ind_pend, push_pend, exc_pend} <= '0;
      end else if (mem.wr && mem_ready) begin
        wr_cnt <= wr_cnt + 2'h1;
      end
      if (mem.rd && mem_ready) begin
        rd_last <= mem_rdata;
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_ready_on_res: assert property (res_valid |-> req_ready)
    else $error("unit busy while result shown");
  a_gen_ind_ill: assert property (tk && req.cls == eau_pkg::CLS_GEN &&
    req.mode == eau_pkg::MODE_MEM_IND |=>
    !(mem.rd || mem.wr) [*3] ##1 res_valid && res.illegal)
    else $error("indirect form accepted outside jumps");
  a_bit_disp_ill: assert property (tk && req.cls == eau_pkg::CLS_BIT &&
    req.mode == eau_pkg::MODE_REG_DISP |-> ##4 res_valid && res.illegal)
    else $error("bit instruction took displacement mode");
  a_bit_imm: assert property (tk && req.cls == eau_pkg::CLS_BIT &&
    req.mode == eau_pkg::MODE_REG_IND && !req.bit_from_reg |-> ##4 res_valid && !res.illegal
    && res.bitnum == $past(req.imm[2:0], 4))
    else $error("bit number not from immediate");
  a_ind_addr: assert property (tk && jm && req.mode == eau_pkg::MODE_MEM_IND |->
    ##3 mem.rd && mem.addr == {24'h0, $past(req.abs_addr[7:0], 3)})
    else $error("indirect read address wrong");
  a_vec_addr: assert property (tk && jm && req.mode == eau_pkg::MODE_EXT_MEM_IND |->
    ##3 mem.rd && mem.addr == eau_pkg::EXT_VEC_BASE + {23'h0, $past(req.abs_addr[6:0], 3), 2'h0})
    else $error("vector read address wrong");
  a_ind_target: assert property (res_valid && ind_pend |-> res.target == rd_last)
    else $error("branch target not the fetched longword");
  a_mem_hold: assert property ((mem.rd || mem.wr) && !mem_ready |=> $stable(mem))
    else $error("memory access changed before ready");
  a_pc_push: assert property (push_pend && mem.wr && wr_cnt == 2'h0 |->
    mem.wdata == pc_hold)
    else $error("pushed pc wrong");
  a_exr_push: assert property (exc_pend && mem.wr && wr_cnt == 2'h1 |->
    mem.wdata == {exr_hold, ccr_hold, 16'h0})
    else $error("pushed control registers wrong");

  c_ind: cover property (tk && req.mode == eau_pkg::MODE_MEM_IND);
  c_ill: cover property (res_valid && res.illegal);
  c_exc: cover property (exc_pend && mem.wr && mem_ready);
endmodule

bind eau_unit eau_chk u_chk (.core_clk(core_clk), .arst_n(arst_n), .req_valid(req_valid),
  .req_ready(req_ready), .req(req), .res_valid(res_valid), .res(res), .mem(mem),
  .mem_ready(mem_ready), .mem_rdata(mem_rdata));
`default_nettype wire

// ---- bench/eau_tb.sv ----
// self-checking bench of the effective address unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  $display("wrong value %s expected %h seen %h", n, e, g); err_total++; end end
module tb;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready, res_valid;
  eau_pkg::eau_req_type req = '0;
  eau_pkg::eau_res_type res;
  eau_pkg::eau_mem_type mem;
  logic mem_ready = 1'b0;
  logic [31:0] mem_rdata = 32'h0;
  logic ext_we = 1'b0;
  logic [2:0] ext_waddr = 3'h0;
  logic [31:0] ext_wdata = 32'h0;
  int err_total = 0;
  int check_count = 0;
  int acc = 0;
  int n0;
  logic [31:0] mv [logic [31:0]];
  logic [31:0] wa, wd;
  eau_pkg::eau_req_type r;

  always #5 core_clk = ~core_clk;

  eau_unit DUT (.core_clk(core_clk), .arst_n(arst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .res_valid(res_valid), .res(res), .mem(mem),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata), .ext_we(ext_we), .ext_waddr(ext_waddr),
    .ext_wdata(ext_wdata));

  // memory stand-in: one wait cycle; idle data toggles so stale reads show
  always @(posedge core_clk) begin
    #1;
    if ((mem.rd || mem.wr) && !mem_ready) begin
      acc++;
      mem_rdata = mv.exists(mem.addr) ? mv[mem.addr] : ~mem_rdata;
      if (mem.wr) begin
        mv[mem.addr] = mem.wdata;
        wa = mem.addr;
        wd = mem.wdata;
      end
      mem_ready = 1'b1;
    end else begin
      mem_ready = 1'b0;
      mem_rdata = ~mem_rdata;
    end
  end

  task automatic conclude;
    if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic run(input eau_pkg::eau_req_type q);
    int n;
    n = 0;
    req = q;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    @(posedge core_clk);
    #1;
    req_valid = 1'b0;
    while (res_valid !== 1'b1 && n < 250) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (res_valid !== 1'b1) begin
      err_total++;
      conclude();
    end
  endtask

  function automatic eau_pkg::eau_req_type mk(eau_pkg::eau_class_type c,
    eau_pkg::eau_mode_type m);
    mk = '0;
    mk.cls = c;
    mk.mode = m;
    mk.size = eau_pkg::SZ_LONG;
  endfunction

  task automatic wreg(input logic [2:0] a, input logic [31:0] v);
    ext_we = 1'b1;
    ext_waddr = a;
    ext_wdata = v;
    @(posedge core_clk);
    #1;
    ext_we = 1'b0;
  endtask

  task automatic rchk(input logic [2:0] a, input logic [31:0] e);
    r = mk(eau_pkg::CLS_GEN, eau_pkg::MODE_REG_DIR);
    r.base_reg = a;
    run(r);
    `CHK("register", e, res.operand)
  endtask

  task automatic eachk(input logic [31:0] e);
    run(r);
    `CHK("ea", e, res.ea)
  endtask

  task automatic t_direct;
    wreg(3'h1, 32'h1234_5678);
    rchk(3'h1, 32'h1234_5678);
    r.size = eau_pkg::SZ_WORD;
    r.reg_hi = 1'b1;
    run(r);
    `CHK("high word", 16'h1234, res.operand[15:0])
    r.size = eau_pkg::SZ_BYTE;
    r.reg_hi = 1'b0;
    run(r);
    `CHK("low byte", 8'h78, res.operand[7:0])
  endtask

  task automatic t_disp;
    wreg(3'h2, 32'h1000_0000);
    r = mk(eau_pkg::CLS_GEN, eau_pkg::MODE_REG_DISP);
    r.base_reg = 3'h2;
    r.disp = 32'h0000_0003;
    eachk(32'h1000_0003);
    r.disp_sel = eau_pkg::DISP_16;
    r.disp = 32'h0000_8000;
    eachk(32'h0fff_8000);
    r.disp_sel = eau_pkg::DISP_32;
    r.disp = 32'h0100_0000;
    eachk(32'h1100_0000);
    r.mode = eau_pkg::MODE_IMM;
    r.imm = 32'h0000_00a5;
    run(r);
    `CHK("immediate", 32'h0000_00a5, res.operand)
    r = mk(eau_pkg::CLS_JUMP, eau_pkg::MODE_PC_REL);
    r.disp_sel = eau_pkg::DISP_8;
    r.disp = 32'h0000_00f0;
    r.pc = 32'h0000_1000;
    run(r);
    `CHK("pc relative", 32'h0000_0ff0, res.target)
    r.mode = eau_pkg::MODE_ABS;
    r.abs_addr = 32'h0012_0000;
    run(r);
    `CHK("absolute", 32'h0012_0000, res.target)
  endtask

  // index byte and word are zero-extended; long wraps below the displacement
  task automatic t_index;
    wreg(3'h4, 32'hffff_ff80);
    r = mk(eau_pkg::CLS_GEN, eau_pkg::MODE_REG_IDX);
    r.index_reg = 3'h4;
    r.disp_sel = eau_pkg::DISP_16;
    r.disp = 32'h0000_1000;
    r.index_size = eau_pkg::SZ_BYTE;
    eachk(32'h0000_1080);
    r.index_size = eau_pkg::SZ_WORD;
    eachk(32'h0001_0f80);
    r.index_size = eau_pkg::SZ_LONG;
    r.disp_sel = eau_pkg::DISP_32;
    eachk(32'h0000_0f80);
    r = mk(eau_pkg::CLS_JUMP, eau_pkg::MODE_PC_IDX);
    r.index_reg = 3'h4;
    r.pc = 32'h0004_0000;
    run(r);
    `CHK("pc index", 32'h0004_0080, res.target)
  endtask

  task automatic t_auto;
    wreg(3'h5, 32'h0000_0100);
    r = mk(eau_pkg::CLS_GEN, eau_pkg::MODE_POST_INC);
    r.base_reg = 3'h5;
    eachk(32'h0000_0100);
    rchk(3'h5, 32'h0000_0104);
    r = mk(eau_pkg::CLS_GEN, eau_pkg::MODE_PRE_DEC);
    r.base_reg = 3'h5;
    r.size = eau_pkg::SZ_BYTE;
    eachk(32'h0000_0103);
    r.mode = eau_pkg::MODE_PRE_INC;
    r.size = eau_pkg::SZ_WORD;
    eachk(32'h0000_0105);
    r.mode = eau_pkg::MODE_POST_DEC;
    eachk(32'h0000_0105);
    rchk(3'h5, 32'h0000_0103);
  endtask

  task automatic t_modes;
    mv[32'h40] = 32'h00ab_cdef;
    mv[32'h14] = 32'h8000_1234;
    r = mk(eau_pkg::CLS_JUMP, eau_pkg::MODE_MEM_IND);
    r.abs_addr = 32'h0000_0040;
    run(r);
    `CHK("indirect", 32'h00ab_cdef, res.target)
    r.mode = eau_pkg::MODE_EXT_MEM_IND;
    r.abs_addr = 32'h0000_0005;
    run(r);
    `CHK("vector", 32'h8000_1234, res.target)
    r.cls = eau_pkg::CLS_GEN;
    r.mode = eau_pkg::MODE_MEM_IND;
    n0 = acc;
    run(r);
    `CHK("gen indirect", 1'b1, res.illegal)
    `CHK("no access", n0, acc)
    r = mk(eau_pkg::CLS_BIT, eau_pkg::MODE_REG_DISP);
    run(r);
    `CHK("bit disp", 1'b1, res.illegal)
    r.mode = eau_pkg::MODE_REG_IND;
    r.imm = 32'h0000_0005;
    run(r);
    `CHK("bit imm", 4'h5, {res.illegal, res.bitnum})
    wreg(3'h6, 32'h0000_0006);
    r.bit_from_reg = 1'b1;
    r.index_reg = 3'h6;
    run(r);
    `CHK("bit reg plain", 1'b1, res.illegal)
    r.cls = eau_pkg::CLS_BIT_SCIT;
    run(r);
    `CHK("bit reg", 4'h6, {res.illegal, res.bitnum})
  endtask

  task automatic t_stack;
    wreg(3'h7, 32'h0000_1000);
    r = mk(eau_pkg::CLS_JSR, eau_pkg::MODE_MEM_IND);
    r.abs_addr = 32'h0000_0040;
    r.pc = 32'h0012_3456;
    run(r);
    `CHK("jsr", {32'h00ab_cdef, 32'h0000_0ffc, 32'h0012_3456}, {res.target, wa, wd})
    r = mk(eau_pkg::CLS_GEN, eau_pkg::MODE_REG_DIR);
    r.op = eau_pkg::OP_RET;
    run(r);
    `CHK("return", 32'h0012_3456, res.target)
    rchk(3'h7, 32'h0000_1000);
    r.op = eau_pkg::OP_EXC_IN;
    r.pc = 32'h0000_2468;
    r.condition_code_reg = 8'h85;
    r.extended_control_reg = 8'h07;
    r.abs_addr = 32'h0000_0200;
    run(r);
    `CHK("exc entry", {32'h200, 32'h0ff8, 32'h0785_0000}, {res.target, wa, wd})
    `CHK("exc pc", 32'h0000_2468, mv[32'h0ffc])
    r.op = eau_pkg::OP_EXC_OUT;
    r.condition_code_reg = 8'h00;
    r.extended_control_reg = 8'h00;
    run(r);
    `CHK("exc exit", {1'b1, 16'h0785, 32'h2468}, {res.restored, res.extended_control_reg,
      res.condition_code_reg, res.target})
    rchk(3'h7, 32'h0000_1000);
    // a call without an indirect read pushes straight from the calculation step
    r = mk(eau_pkg::CLS_JSR, eau_pkg::MODE_ABS);
    r.abs_addr = 32'h0000_0300;
    r.pc = 32'h0000_0550;
    run(r);
    `CHK("jsr abs", {32'h0000_0300, 32'h0000_0ffc, 32'h0000_0550}, {res.target, wa, wd})
    rchk(3'h7, 32'h0000_0ffc);
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    t_direct();
    t_disp();
    t_index();
    t_auto();
    t_modes();
    t_stack();
    conclude();
  end
endmodule
`default_nettype wire
